/* phy_status_and_id_regs.sv */
// management register block: basic status word and high identifier word over mdc/mdio
`timescale 1ns/1ps

module phy_status_and_id_regs #(
   parameter logic [15:0] ID_HIGH_VALUE = 16'h0A5C  // arbitrary value
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire logic [4:0]                  i_phy_addr,
   input  wire logic                        i_mdc,
   input  wire logic                        i_mdio,
   input  wire phy_mgmt_pkg::phy_status_s   i_status,
   output phy_mgmt_pkg::mdio_drive_s        o_mdio,
   output logic [15:0]                      o_status_word
);

   typedef enum logic [2:0] {
      ST_PRE,
      ST_HDR,
      ST_TA,
      ST_READ,
      ST_SKIP
   } frame_e;

   frame_e      state_r,  state_nxt;
   logic        mdc_r,    mdc_nxt;
   logic [5:0]  ones_r,   ones_nxt;
   logic [4:0]  cnt_r,    cnt_nxt;
   logic [12:0] hdr_r,    hdr_nxt;
   logic [15:0] shift_r,  shift_nxt;
   logic        out_r,    out_nxt;
   logic        oe_r,     oe_nxt;
   logic        aneg_r,   aneg_nxt;
   logic        rf_r,     rf_nxt;
   logic        link_r,   link_nxt;
   logic        jab_r,    jab_nxt;

   // combinational helpers
   logic        rise;
   logic        sts_read;
   logic [12:0] hdr_full;
   logic [15:0] status_word;
   logic [15:0] read_data;

   // mdc rise against the previous sample
   assign rise     = i_mdc & ~mdc_r;
   assign hdr_full = {hdr_r[11:0], i_mdio};

   // compose the status word
   always_comb begin
      status_word = 16'h0000;
      status_word[phy_mgmt_pkg::STS_ABIL_HI_BIT:phy_mgmt_pkg::STS_ABIL_LO_BIT] = 4'hF;
      status_word[phy_mgmt_pkg::STS_T4_BIT]        = 1'b0;
      status_word[phy_mgmt_pkg::STS_RSVD_HI_BIT:phy_mgmt_pkg::STS_RSVD_LO_BIT] = 4'h0;
      status_word[phy_mgmt_pkg::STS_PRE_SKIP_BIT]  = 1'b0;
      status_word[phy_mgmt_pkg::STS_ANEG_CPL_BIT]  = aneg_r;
      status_word[phy_mgmt_pkg::STS_RFAULT_BIT]    = rf_r;
      status_word[phy_mgmt_pkg::STS_ANEG_ABL_BIT]  = 1'b1;
      status_word[phy_mgmt_pkg::STS_EXT_CAP_BIT]   = 1'b1;
      status_word[phy_mgmt_pkg::STS_LINK_BIT]      = link_r;
      status_word[phy_mgmt_pkg::STS_JABBER_BIT]    = jab_r;
   end

   // address decode of a read frame, unmapped registers read zero
   always_comb begin
      case (hdr_full[4:0])
         phy_mgmt_pkg::REG_BASIC_STATUS: read_data = status_word;
         phy_mgmt_pkg::REG_ID_HIGH:      read_data = ID_HIGH_VALUE;
         default:                        read_data = 16'h0000;
      endcase
   end

   // frame sequencer next state
   always_comb begin
      state_nxt = state_r;
      mdc_nxt   = i_mdc;
      ones_nxt  = ones_r;
      cnt_nxt   = cnt_r;
      hdr_nxt   = hdr_r;
      shift_nxt = shift_r;
      out_nxt   = out_r;
      oe_nxt    = oe_r;
      sts_read  = 1'b0;
      if (rise) begin
         case (state_r)
            // only a full preamble opens a frame
            ST_PRE: begin
               if (i_mdio) begin
                  if (ones_r != phy_mgmt_pkg::PREAMBLE_BITS) begin
                     ones_nxt = ones_r + 6'h01;
                  end
               end else if (ones_r == phy_mgmt_pkg::PREAMBLE_BITS) begin
                  state_nxt = ST_HDR;
                  cnt_nxt   = 5'h00;
                  ones_nxt  = 6'h00;
               end else begin
                  ones_nxt = 6'h00;
               end
            end
            ST_HDR: begin
               hdr_nxt = hdr_full;
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == phy_mgmt_pkg::HDR_LAST_BIT) begin
                  cnt_nxt = 5'h00;
                  if (hdr_full[12] && hdr_full[11:10] == phy_mgmt_pkg::OP_READ
                      && hdr_full[9:5] == i_phy_addr) begin
                     state_nxt = ST_TA;
                     shift_nxt = read_data;
                     sts_read  = (hdr_full[4:0] == phy_mgmt_pkg::REG_BASIC_STATUS);
                  end else begin
                     state_nxt = ST_SKIP;
                  end
               end
            end
            // turnaround, second bit driven low
            ST_TA: begin
               oe_nxt    = 1'b1;
               out_nxt   = 1'b0;
               state_nxt = ST_READ;
            end
            ST_READ: begin
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == phy_mgmt_pkg::DATA_BITS) begin
                  oe_nxt    = 1'b0;
                  out_nxt   = 1'b0;
                  state_nxt = ST_PRE;
                  cnt_nxt   = 5'h00;
               end else begin
                  // snapshot leaves msb first
                  out_nxt   = shift_r[15];
                  shift_nxt = {shift_r[14:0], 1'b0};
               end
            end
            // let a refused frame pass by
            ST_SKIP: begin
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == phy_mgmt_pkg::SKIP_LAST_BIT) begin
                  state_nxt = ST_PRE;
                  cnt_nxt   = 5'h00;
               end
            end
            // recover from an illegal state
            default: begin
               state_nxt = ST_PRE;
               oe_nxt    = 1'b0;
            end
         endcase
      end
   end

   // latched status next values, a new event beats the read clear
   always_comb begin
      aneg_nxt = (sts_read ? 1'b0 : aneg_r) | i_status.aneg_done;
      rf_nxt   = (sts_read ? 1'b0 : rf_r) | i_status.remote_fault;
      link_nxt = (sts_read ? 1'b1 : link_r) & i_status.link_up;
      jab_nxt  = (sts_read ? 1'b0 : jab_r) | i_status.jabber;
   end

   // frame sequencer registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_r <= ST_PRE;
         mdc_r   <= 1'b0;
         ones_r  <= 6'h00;
         cnt_r   <= 5'h00;
         hdr_r   <= 13'h0000;
         shift_r <= 16'h0000;
         out_r   <= 1'b0;
         oe_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mdc_r   <= mdc_nxt;
         ones_r  <= ones_nxt;
         cnt_r   <= cnt_nxt;
         hdr_r   <= hdr_nxt;
         shift_r <= shift_nxt;
         out_r   <= out_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // status latch registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aneg_r  <= phy_mgmt_pkg::RST_ANEG_CPL;
         rf_r    <= phy_mgmt_pkg::RST_RFAULT;
         link_r  <= phy_mgmt_pkg::RST_LINK;
         jab_r   <= phy_mgmt_pkg::RST_JABBER;
      end else begin
         aneg_r  <= aneg_nxt;
         rf_r    <= rf_nxt;
         link_r  <= link_nxt;
         jab_r   <= jab_nxt;
      end
   end

   assign o_mdio        = '{
      mdio_o:  out_r,
      mdio_oe: oe_r
   };
   assign o_status_word = status_word;

endmodule

/* phy_mgmt_pkg.sv */
// constants, register map and status carrier for the management register block
package phy_mgmt_pkg;

   // register addresses on the management bus
   localparam logic [4:0] REG_BASIC_STATUS  = 5'h01;
   localparam logic [4:0] REG_ID_HIGH       = 5'h02;

   // basic status word bit positions
   localparam int unsigned STS_T4_BIT       = 15;
   localparam int unsigned STS_ABIL_HI_BIT  = 14;
   localparam int unsigned STS_ABIL_LO_BIT  = 11;
   localparam int unsigned STS_RSVD_HI_BIT  = 10;
   localparam int unsigned STS_RSVD_LO_BIT  = 7;
   localparam int unsigned STS_PRE_SKIP_BIT = 6;
   localparam int unsigned STS_ANEG_CPL_BIT = 5;
   localparam int unsigned STS_RFAULT_BIT   = 4;
   localparam int unsigned STS_ANEG_ABL_BIT = 3;
   localparam int unsigned STS_LINK_BIT     = 2;
   localparam int unsigned STS_JABBER_BIT   = 1;
   localparam int unsigned STS_EXT_CAP_BIT  = 0;

   // reset values of the latched status bits
   localparam logic RST_ANEG_CPL = 1'b0;
   localparam logic RST_RFAULT   = 1'b0;
   localparam logic RST_LINK     = 1'b0;
   localparam logic RST_JABBER   = 1'b0;

   // management frame layout, counted in bits
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [4:0] HDR_LAST_BIT  = 5'h0C;
   localparam logic [4:0] DATA_BITS     = 5'h10;
   localparam logic [4:0] SKIP_LAST_BIT = 5'h11;
   localparam logic [1:0] OP_READ       = 2'b10;

   // status events from the negotiation and link logic
   typedef struct packed {
      logic aneg_done;
      logic remote_fault;
      logic link_up;
      logic jabber;
   } phy_status_s;

   // management pin group
   typedef struct packed {
      logic mdio_o;
      logic mdio_oe;
   } mdio_drive_s;

endpackage

/* phy_status_and_id_regs_monitor.sv */
// checker of the status word constant bits and latches
`timescale 1ns/1ps
module phy_status_mon (
   input wire logic                      i_clk,
   input wire logic                      i_rst_n,
   input wire phy_mgmt_pkg::phy_status_s i_status,
   input wire phy_mgmt_pkg::mdio_drive_s o_mdio,
   input wire logic [15:0]               o_status_word
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_ability_bits:
      assert property (o_status_word[15:11] == 5'h0F) else $error("ability bits wrong");
   a_preamble_req:
      assert property (!o_status_word[6]) else $error("preamble bit set");
   a_aneg_latch:
      assert property (i_status.aneg_done |=> o_status_word[5]) else $error("aneg not latched");
   a_rfault_latch:
      assert property (i_status.remote_fault |=> o_status_word[4]) else $error("fault lost");
   a_fixed_ones:
      assert property (o_status_word[3] && o_status_word[0]) else $error("fixed ones wrong");
   a_link_low:
      assert property (!i_status.link_up |=> !o_status_word[2]) else $error("link not low");
   a_jabber_latch:
      assert property (i_status.jabber |=> o_status_word[1]) else $error("jabber lost");
   a_reserved_zero:
      assert property (o_status_word[10:7] == 4'h0) else $error("reserved bits set");
   a_aneg_hold:
      assert property ($fell(o_status_word[5]) |-> ##[1:250] $rose(o_mdio.mdio_oe))
         else $error("aneg cleared without read");
   a_rfault_hold:
      assert property ($fell(o_status_word[4]) |-> ##[1:250] $rose(o_mdio.mdio_oe))
         else $error("fault cleared without read");
   a_link_hold:
      assert property ($rose(o_status_word[2]) |-> ##[1:250] $rose(o_mdio.mdio_oe))
         else $error("link restored without read");
   a_jabber_hold:
      assert property ($fell(o_status_word[1]) |-> ##[1:250] $rose(o_mdio.mdio_oe))
         else $error("jabber cleared without read");
   cover property (i_status.jabber ##1 !i_status.jabber);
   cover property ($rose(o_mdio.mdio_oe));
   cover property ($fell(o_status_word[2]));
endmodule

bind phy_status_and_id_regs phy_status_mon mon_inst (
   .i_clk         (i_clk),
   .i_rst_n       (i_rst_n),
   .i_status      (i_status),
   .o_mdio        (o_mdio),
   .o_status_word (o_status_word)
);

/* sta_model.sv */
// station management controller model driving mdc and mdio
`timescale 1ns/1ps
module sta_model (
   input  wire logic i_clk,
   input  wire logic i_line,
   output logic      o_mdc,
   output logic      o_drv_en,
   output logic      o_drv
);
   initial begin
      o_mdc = 1'b0;
      o_drv_en = 1'b0;
      o_drv = 1'b1;
   end
   // one bit: two clocks low, sample, two clocks high
   task automatic bit_x(input logic d, input logic en, output logic s);
      @(negedge i_clk);
      o_mdc = 1'b0;
      o_drv = d;
      o_drv_en = en;
      repeat (2) @(negedge i_clk);
      s = i_line;
      o_mdc = 1'b1;
      @(negedge i_clk);
   endtask
   task automatic frame(input logic [4:0] a, input logic [4:0] r, input logic [1:0] op,
                        input int np, input logic [17:0] w, output logic [17:0] t);
      logic [13:0] h;
      logic        s;
      h = {2'h1, op, a, r};
      for (int i = 0; i < np; i++) bit_x(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_x(h[i], 1'b1, s);
      for (int i = 17; i >= 0; i--) begin
         bit_x(w[i], op == 2'h1, s);
         t[i] = s;
      end
      @(negedge i_clk);
      o_mdc = 1'b0;
      o_drv_en = 1'b0;
   endtask
endmodule

/* testbench.sv */
// self-checking bench of the status and identifier registers
`timescale 1ns/1ps
module testbench;
   logic                      clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic                      mdc, drv_en, drv, line;
   logic [4:0]                pa;
   logic [17:0]               q[$];
   logic [17:0]               res;
   logic [15:0]               sts;
   phy_mgmt_pkg::phy_status_s st_in;
   phy_mgmt_pkg::mdio_drive_s mdo;
   int                        n_mismatch = 0;
   int                        tests_run = 0;
   event                      done;
   always #4 clk = ~clk;
   assign line = mdo.mdio_oe ? mdo.mdio_o : (drv_en ? drv : 1'b1);
   phy_status_and_id_regs #(.ID_HIGH_VALUE(16'h1234)) phy_status_and_id_regs_inst (
      .i_clk(clk), .i_rst_n(rst_n), .i_phy_addr(pa), .i_mdc(mdc), .i_mdio(line),
      .i_status(st_in), .o_mdio(mdo), .o_status_word(sts));
   sta_model sta_model_inst (
      .i_clk(clk), .i_line(line), .o_mdc(mdc), .o_drv_en(drv_en), .o_drv(drv));
   function automatic logic [17:0] sw(input logic [3:0] v);
      return {2'h2, 1'b0, 4'hF, 4'h0, 1'b0, v[3:2], 1'b1, v[1:0], 1'b1};
   endfunction
   task automatic summarize;
      if (q.size() != 0) n_mismatch++;
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [17:0] e, input logic [17:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %0t frame got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [4:0] r, input logic [1:0] op,
                     input int np, input logic [17:0] e);
      q.push_back(e);
      sta_model_inst.frame(a, r, op, np, e, res);
      ->done;
   endtask
   task automatic peek(input logic [17:0] e);
      q.push_back(e);
      @(negedge clk);
      res = {2'h2, sts};
      ->done;
   endtask
   always @(done) chk(q.pop_front(), res);
   task automatic ev(input logic [3:0] v, input logic [3:0] w);
      @(negedge clk);
      st_in = v;
      @(negedge clk);
      st_in = w;
   endtask
   initial begin
      void'($urandom(40816));
      st_in = 4'h0;
      pa = 5'($urandom);
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      peek(sw(4'h0));
      rd(pa, 5'h01, 2'h2, 32, sw(4'h0));
      rd(pa, 5'h02, 2'h2, 32, {2'h2, 16'h1234});
      rd(pa, 5'(3 + $urandom % 29), 2'h2, 32, {2'h2, 16'h0000});
      rd(pa ^ 5'(1 + $urandom % 31), 5'h01, 2'h2, 32, 18'h3_FFFF);
      rd(pa, 5'h01, 2'h2, 31, 18'h3_FFFF);
      rd(pa, 5'h01, 2'h1, 32, 18'($urandom));
      ev(4'hF, 4'hA);
      peek(sw(4'hD));
      rd(pa, 5'h01, 2'h2, 32, sw(4'hD));
      rd(pa, 5'h01, 2'h2, 32, sw(4'hA));
      ev(4'h8, 4'hA);
      rd(pa, 5'h01, 2'h2, 32, sw(4'h8));
      rd(pa, 5'h01, 2'h2, 32, sw(4'hA));
      ev(4'h2, 4'h2);
      rd(pa, 5'h01, 2'h2, 32, sw(4'hA));
      rd(pa, 5'h01, 2'h2, 32, sw(4'h2));
      @(negedge clk);
      summarize();
   end
   initial begin
      #200us;
      n_mismatch++;
      summarize();
   end
endmodule
